// ---- acta_top.sv ----
// Summary of operation
// - gain field selects full-scale range
// - mode bit: continuous or single-shot
// - rate field selects conversion rate
// - comparator type: hysteresis or window
// - polarity bit sets alert active level
// - non-latching alert releases below low in hysteresis, within margins in window
// - alert response sends address, lowest wins
// - assert after 1, 2 or 4 conversions
// - two signed 16-bit threshold registers
// - threshold sign bits select ready signalling
// - single-shot ready shows operational status
// - continuous ready pulses per conversion
// - low at 10b reset 8000h, high 11b
`timescale 1ns/10ps
`default_nettype none
`include "acta_map.svh"
module acta_top
  import acta_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // avalon-mm slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // converter core, on its own clock
  input wire logic CONV_CLK,
  input wire logic CONV_DONE,
  input wire logic CONV_BUSY,
  input wire logic [15:0] CONV_DATA,
  // settings and start towards the core
  output logic [2:0] GAIN_RANGE_SELECT,
  output logic SINGLE_SHOT_MODE,
  output logic [2:0] SAMPLE_RATE_SELECT,
  output logic CONV_START,
  // alert/ready pin
  output logic ALERT_O,
  output logic ALERT_OE,
  // alert response address phase from the serial engine
  input wire logic [6:0] DEV_ADDR,
  input wire logic ARA_START,
  input wire logic ARA_BIT_STROBE,
  input wire logic ARA_SDA_IN,
  output logic ARA_SDA_O,
  output logic ARA_SDA_OE,
  output logic ARA_WON,
  // interrupt
  output logic IRQ
);

  acta_cfg_t cfg_reg;
  logic [15:0] low_thr_reg;
  logic [15:0] high_thr_reg;
  logic [15:0] result_reg;
  logic [`ACTA_ST_W-1:0] status_reg;
  logic [`ACTA_ST_W-1:0] mask_reg;
  acta_conv_t sync1_reg;
  acta_conv_t sync2_reg;
  logic conv_clk_prev_reg;
  logic [6:0] addr_s1_reg;
  logic [6:0] addr_s2_reg;
  logic [2:0] exceed_cnt_reg;
  logic alert_cmp_reg;
  logic [3:0] rdy_cnt_reg;
  acta_ara_state_t ara_state_reg;
  logic [2:0] ara_bit_reg;
  logic ara_lost_reg;

  logic req;
  logic accept;
  logic wr_acc;
  logic rd_acc;
  logic [2:0] idx;
  logic conv_evt;
  logic os_bit;
  logic rdy_mode;
  logic comp_on;
  logic beyond_hi;
  logic beyond_lo;
  logic exceed;
  logic [2:0] cnt_next;
  logic [2:0] needed;
  logic alert_clear;
  logic asserted;
  logic [`ACTA_ST_W-1:0] status_set;
  logic ara_win;

  function automatic logic [15:0] cfg_word(input acta_cfg_t c, input logic os);
    cfg_word = {os, 3'h0, c.gain_range_select, c.single_shot_mode,
                c.sample_rate_select, c.window_mode, c.alert_polarity,
                c.alert_latch_enable, c.alert_queue_count};
  endfunction : cfg_word

  // bus handshake: one wait cycle, accepted at the edge waitrequest is low
  assign req = AVS_READ | AVS_WRITE;
  assign accept = req & ~AVS_WAITREQUEST;
  assign wr_acc = accept & AVS_WRITE;
  assign rd_acc = accept & AVS_READ;
  assign idx = AVS_ADDRESS[4:2];

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (req & AVS_WAITREQUEST) begin
      case (idx)
        `ACTA_IDX_RESULT: AVS_READDATA <= {16'h0000, result_reg};
        `ACTA_IDX_CONFIG: AVS_READDATA <= {16'h0000, cfg_word(cfg_reg, os_bit)};
        `ACTA_IDX_LOW_THR: AVS_READDATA <= {16'h0000, low_thr_reg};
        `ACTA_IDX_HIGH_THR: AVS_READDATA <= {16'h0000, high_thr_reg};
        `ACTA_IDX_STATUS: AVS_READDATA <= {29'h0000_0000, status_reg};
        `ACTA_IDX_MASK: AVS_READDATA <= {29'h0000_0000, mask_reg};
        default: AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // converter inputs cross in through two flops
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      conv_clk_prev_reg <= 1'b0;
      addr_s1_reg <= 7'h00;
      addr_s2_reg <= 7'h00;
    end else begin
      sync1_reg <= {CONV_CLK, CONV_DONE, CONV_BUSY, CONV_DATA};
      sync2_reg <= sync1_reg;
      conv_clk_prev_reg <= sync2_reg.clk;
      addr_s1_reg <= DEV_ADDR;
      addr_s2_reg <= addr_s1_reg;
    end
  end

  // data and done are stable across a whole link clock, so one edge suffices
  assign conv_evt = sync2_reg.clk & ~conv_clk_prev_reg & sync2_reg.done;
  assign os_bit = ~sync2_reg.busy;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      result_reg <= 16'h0000;
    end else if (conv_evt) begin
      result_reg <= sync2_reg.data;
    end
  end

  // configuration register
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cfg_reg.gain_range_select <= `ACTA_RST_GAIN;
      cfg_reg.single_shot_mode <= `ACTA_RST_MODE;
      cfg_reg.sample_rate_select <= `ACTA_RST_RATE;
      cfg_reg.window_mode <= 1'b0;
      cfg_reg.alert_polarity <= 1'b0;
      cfg_reg.alert_latch_enable <= 1'b0;
      cfg_reg.alert_queue_count <= `ACTA_RST_QUE;
    end else if (wr_acc && idx == `ACTA_IDX_CONFIG) begin
      if (AVS_BYTEENABLE[1]) begin
        cfg_reg.gain_range_select <= AVS_WRITEDATA[`ACTA_CFG_GAIN_HI:`ACTA_CFG_GAIN_LO];
        cfg_reg.single_shot_mode <= AVS_WRITEDATA[`ACTA_CFG_MODE];
      end
      if (AVS_BYTEENABLE[0]) begin
        cfg_reg.sample_rate_select <= AVS_WRITEDATA[`ACTA_CFG_RATE_HI:`ACTA_CFG_RATE_LO];
        cfg_reg.window_mode <= AVS_WRITEDATA[`ACTA_CFG_CMODE];
        cfg_reg.alert_polarity <= AVS_WRITEDATA[`ACTA_CFG_POL];
        cfg_reg.alert_latch_enable <= AVS_WRITEDATA[`ACTA_CFG_LAT];
        cfg_reg.alert_queue_count <= AVS_WRITEDATA[`ACTA_CFG_QUE_HI:`ACTA_CFG_QUE_LO];
      end
    end
  end

  // settings go to the core through output flops, one cycle after the stored fields
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      GAIN_RANGE_SELECT <= `ACTA_RST_GAIN;
      SINGLE_SHOT_MODE <= `ACTA_RST_MODE;
      SAMPLE_RATE_SELECT <= `ACTA_RST_RATE;
      CONV_START <= 1'b0;
    end else begin
      GAIN_RANGE_SELECT <= cfg_reg.gain_range_select;
      SINGLE_SHOT_MODE <= cfg_reg.single_shot_mode;
      SAMPLE_RATE_SELECT <= cfg_reg.sample_rate_select;
      // start only honoured while powered down and idle
      CONV_START <= wr_acc && idx == `ACTA_IDX_CONFIG && AVS_BYTEENABLE[1] &&
                    AVS_WRITEDATA[`ACTA_CFG_OS] && cfg_reg.single_shot_mode && os_bit;
    end
  end

  // threshold registers, both steer the comparator
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      low_thr_reg <= `ACTA_RST_LOW_THR;
      high_thr_reg <= `ACTA_RST_HIGH_THR;
    end else if (wr_acc) begin
      if (idx == `ACTA_IDX_LOW_THR) begin
        if (AVS_BYTEENABLE[0]) low_thr_reg[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) low_thr_reg[15:8] <= AVS_WRITEDATA[15:8];
      end
      if (idx == `ACTA_IDX_HIGH_THR) begin
        if (AVS_BYTEENABLE[0]) high_thr_reg[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) high_thr_reg[15:8] <= AVS_WRITEDATA[15:8];
      end
    end
  end

  // comparator; no hardware check of high above low, the host owns that
  assign rdy_mode = high_thr_reg[15] & ~low_thr_reg[15];
  assign comp_on = cfg_reg.alert_queue_count != `ACTA_QUE_OFF;
  assign beyond_hi = $signed(sync2_reg.data) > $signed(high_thr_reg);
  assign beyond_lo = $signed(sync2_reg.data) < $signed(low_thr_reg);
  assign exceed = cfg_reg.window_mode ? (beyond_hi | beyond_lo) : beyond_hi;

  always_comb begin
    case (cfg_reg.alert_queue_count)
      `ACTA_QUE_ONE: needed = 3'h1;
      `ACTA_QUE_TWO: needed = 3'h2;
      `ACTA_QUE_FOUR: needed = 3'h4;
      default: needed = 3'h7;
    endcase
  end

  assign cnt_next = (exceed_cnt_reg == 3'h7) ? exceed_cnt_reg : exceed_cnt_reg + 3'h1;
  assign alert_clear = cfg_reg.alert_latch_enable &
                       ((rd_acc && idx == `ACTA_IDX_RESULT) | ara_win);

  always_ff @(posedge CORE_CLK) begin
    if (RESET || !comp_on || rdy_mode) begin
      exceed_cnt_reg <= 3'h0;
    end else if (conv_evt) begin
      exceed_cnt_reg <= exceed ? cnt_next : 3'h0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || !comp_on || rdy_mode) begin
      alert_cmp_reg <= 1'b0;
    end else if (conv_evt && exceed && cnt_next >= needed) begin
      alert_cmp_reg <= 1'b1;
    end else if (alert_clear) begin
      alert_cmp_reg <= 1'b0;
    end else if (conv_evt && !cfg_reg.alert_latch_enable) begin
      // hysteresis releases below low only; window releases once back inside
      if (cfg_reg.window_mode ? !exceed : beyond_lo) begin
        alert_cmp_reg <= 1'b0;
      end
    end
  end

  // ready pulse stretched so slow external logic can see it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rdy_cnt_reg <= 4'h0;
    end else if (conv_evt && !cfg_reg.single_shot_mode) begin
      rdy_cnt_reg <= 4'(`ACTA_RDY_PULSE_CYC);
    end else if (rdy_cnt_reg != 4'h0) begin
      rdy_cnt_reg <= rdy_cnt_reg - 4'h1;
    end
  end

  always_comb begin
    if (rdy_mode) begin
      asserted = cfg_reg.single_shot_mode ? os_bit : (rdy_cnt_reg != 4'h0);
    end else begin
      asserted = alert_cmp_reg;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ALERT_O <= 1'b1;
      ALERT_OE <= 1'b0;
    end else begin
      ALERT_O <= cfg_reg.alert_polarity ? asserted : ~asserted;
      ALERT_OE <= comp_on;
    end
  end

  // alert response: address sent msb first, open drain, low bits win
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ara_state_reg <= ARA_IDLE;
      ara_bit_reg <= 3'h0;
      ara_lost_reg <= 1'b0;
    end else begin
      case (ara_state_reg)
        ARA_IDLE: begin
          if (ARA_START && alert_cmp_reg) begin
            ara_state_reg <= ARA_SEND;
            ara_bit_reg <= 3'h6;
            ara_lost_reg <= 1'b0;
          end
        end
        ARA_SEND: begin
          if (ARA_BIT_STROBE) begin
            // released a one but the line is low: a lower address is on the bus
            if (addr_s2_reg[ara_bit_reg] && !ARA_SDA_IN) begin
              ara_lost_reg <= 1'b1;
            end
            if (ara_bit_reg == 3'h0) begin
              ara_state_reg <= ARA_FINISH;
            end else begin
              ara_bit_reg <= ara_bit_reg - 3'h1;
            end
          end
        end
        ARA_FINISH: ara_state_reg <= ARA_IDLE;
        default: ara_state_reg <= ARA_IDLE;
      endcase
    end
  end

  assign ara_win = ara_state_reg == ARA_FINISH && !ara_lost_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ARA_SDA_O <= 1'b0;
      ARA_SDA_OE <= 1'b0;
      ARA_WON <= 1'b0;
    end else begin
      ARA_SDA_O <= 1'b0;
      ARA_SDA_OE <= ara_state_reg == ARA_SEND && !ara_lost_reg &&
                    !addr_s2_reg[ara_bit_reg] &&
                    !(ARA_BIT_STROBE && ara_bit_reg == 3'h0);
      ARA_WON <= ara_win;
    end
  end

  // interrupt status, write one to clear, a new event wins over the clear
  always_comb begin
    status_set = '0;
    status_set[`ACTA_ST_ALERT] = conv_evt && exceed && cnt_next >= needed &&
                                 comp_on && !rdy_mode && !alert_cmp_reg;
    status_set[`ACTA_ST_CONV] = conv_evt;
    status_set[`ACTA_ST_ARA] = ara_win;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      status_reg <= '0;
    end else if (wr_acc && idx == `ACTA_IDX_STATUS && AVS_BYTEENABLE[0]) begin
      status_reg <= (status_reg & ~AVS_WRITEDATA[`ACTA_ST_W-1:0]) | status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mask_reg <= '0;
    end else if (wr_acc && idx == `ACTA_IDX_MASK && AVS_BYTEENABLE[0]) begin
      mask_reg <= AVS_WRITEDATA[`ACTA_ST_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_reg & mask_reg);
    end
  end

endmodule : acta_top
`default_nettype wire

// ---- acta_map.svh ----
`ifndef ACTA_MAP_SVH
`define ACTA_MAP_SVH
// register indices; byte address is four times the index
`define ACTA_IDX_RESULT 3'h0
`define ACTA_IDX_CONFIG 3'h1
`define ACTA_IDX_LOW_THR 3'h2
`define ACTA_IDX_HIGH_THR 3'h3
`define ACTA_IDX_STATUS 3'h4
`define ACTA_IDX_MASK 3'h5
// converter_configuration fields
`define ACTA_CFG_OS 15
`define ACTA_CFG_GAIN_HI 11
`define ACTA_CFG_GAIN_LO 9
`define ACTA_CFG_MODE 8
`define ACTA_CFG_RATE_HI 7
`define ACTA_CFG_RATE_LO 5
`define ACTA_CFG_CMODE 4
`define ACTA_CFG_POL 3
`define ACTA_CFG_LAT 2
`define ACTA_CFG_QUE_HI 1
`define ACTA_CFG_QUE_LO 0
// reset values
`define ACTA_RST_GAIN 3'h2
`define ACTA_RST_MODE 1'b1
`define ACTA_RST_RATE 3'h4
`define ACTA_RST_QUE 2'h3
`define ACTA_RST_LOW_THR 16'h8000
`define ACTA_RST_HIGH_THR 16'h7fff
// queue codes
`define ACTA_QUE_ONE 2'h0
`define ACTA_QUE_TWO 2'h1
`define ACTA_QUE_FOUR 2'h2
`define ACTA_QUE_OFF 2'h3
// status bits: alert raised, conversion taken, alert response won
`define ACTA_ST_ALERT 0
`define ACTA_ST_CONV 1
`define ACTA_ST_ARA 2
`define ACTA_ST_W 3
// ready pulse length
`define ACTA_CLK_PERIOD_NS 5
`define ACTA_RDY_PULSE_NS 40
`define ACTA_RDY_PULSE_CYC ((`ACTA_RDY_PULSE_NS + `ACTA_CLK_PERIOD_NS - 1) / `ACTA_CLK_PERIOD_NS)
`define ACTA_ADDR_BITS 7
`endif

// ---- acta_pkg.sv ----
`default_nettype none
package acta_pkg;
  typedef struct packed {
    logic [2:0] gain_range_select;
    logic single_shot_mode;
    logic [2:0] sample_rate_select;
    logic window_mode;
    logic alert_polarity;
    logic alert_latch_enable;
    logic [1:0] alert_queue_count;
  } acta_cfg_t;

  typedef struct packed {
    logic clk;
    logic done;
    logic busy;
    logic [15:0] data;
  } acta_conv_t;

  // gray order along idle -> send -> finish
  typedef enum logic [1:0] {
    ARA_IDLE = 2'b00,
    ARA_SEND = 2'b01,
    ARA_FINISH = 2'b11
  } acta_ara_state_t;
endpackage : acta_pkg
`default_nettype wire

// ---- acta_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module acta_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // register bus
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  // converter settings and pin
  input wire logic [2:0] GAIN_RANGE_SELECT,
  input wire logic SINGLE_SHOT_MODE,
  input wire logic [2:0] SAMPLE_RATE_SELECT,
  input wire logic CONV_START,
  input wire logic ALERT_OE,
  // alert response
  input wire logic ARA_BIT_STROBE,
  input wire logic ARA_SDA_IN,
  input wire logic ARA_SDA_OE,
  input wire logic ARA_WON
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic cfg_wr;
  logic [1:0] que_reg;
  assign cfg_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == 3'h1;
  // shadow of the queue field, the pin enable is judged against it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      que_reg <= 2'h3;
    end else if (cfg_wr && AVS_BYTEENABLE[0]) begin
      que_reg <= AVS_WRITEDATA[1:0];
    end
  end
  a_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered");
  a_pin_enable: assert property ($stable(que_reg) [*2] |-> ALERT_OE == (que_reg != 2'h3))
    else $error("alert enable wrong");
  a_gain_copy: assert property (cfg_wr && AVS_BYTEENABLE[1] |=> ##1
    GAIN_RANGE_SELECT == $past(AVS_WRITEDATA[11:9], 2) && SINGLE_SHOT_MODE == $past(AVS_WRITEDATA[8], 2))
    else $error("gain or mode copy wrong");
  a_rate_copy: assert property (cfg_wr && AVS_BYTEENABLE[0] |=> ##1
    SAMPLE_RATE_SELECT == $past(AVS_WRITEDATA[7:5], 2))
    else $error("rate copy wrong");
  a_start_pulse: assert property (CONV_START |=> !CONV_START)
    else $error("start longer than one cycle");
  a_won_pulse: assert property (ARA_WON |=> !ARA_WON)
    else $error("won longer than one cycle");
  a_ara_lost: assert property (ARA_BIT_STROBE && !ARA_SDA_OE && !ARA_SDA_IN |=>
    (!ARA_SDA_OE && !ARA_WON) [*6])
    else $error("drives after losing");
endmodule : acta_chk
`default_nettype wire

// ---- acta_conv_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module acta_conv_model (
  // request from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [15:0] value,
  // link towards the block
  output logic clk,
  output logic done,
  output logic busy,
  output logic [15:0] data
);
  initial begin
    clk = 1'h0;
    done = 1'h0;
    busy = 1'h0;
    data = 16'h0000;
  end
  // clock only runs inside a frame; data turns over once released
  always @(posedge go) begin
    busy = 1'h1;
    #(slow ? 403 : 83);
    data = value;
    done = 1'h1;
    #80 clk = 1'h1;
    #80 clk = 1'h0;
    done = 1'h0;
    busy = 1'h0;
    data = ~value;
  end
endmodule : acta_conv_model
`default_nettype wire

// ---- adc_config_threshold_alert_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_config_threshold_alert_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic go = 1'h0;
  logic slow = 1'h0;
  logic [15:0] val = 16'h0000;
  logic ara_go = 1'h0;
  logic stb = 1'h0;
  logic other = 1'h1;
  logic cclk, cdone, cbusy, wt, start, alert, oe, sda_o, sda_oe, won, irq, ss, sda, seen;
  logic [15:0] cdata;
  logic [31:0] rdata, q;
  logic [2:0] gain, rate, g;
  int hi;
  int err_count = 0;
  int tests_run = 0;
  // open-drain line with pull-up
  assign sda = !sda_oe && other;
  always #2.5 clk = ~clk;
  acta_conv_model conv_side (.go(go), .slow(slow), .value(val), .clk(cclk), .done(cdone),
    .busy(cbusy), .data(cdata));
  acta_top uut (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wt),
    .CONV_CLK(cclk), .CONV_DONE(cdone), .CONV_BUSY(cbusy), .CONV_DATA(cdata),
    .GAIN_RANGE_SELECT(gain), .SINGLE_SHOT_MODE(ss), .SAMPLE_RATE_SELECT(rate),
    .CONV_START(start), .ALERT_O(alert), .ALERT_OE(oe), .DEV_ADDR(7'h2a), .ARA_START(ara_go),
    .ARA_BIT_STROBE(stb), .ARA_SDA_IN(sda), .ARA_SDA_O(sda_o), .ARA_SDA_OE(sda_oe),
    .ARA_WON(won), .IRQ(irq));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic bus(input logic w, input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= {idx, 2'h0};
    wd <= {16'h0000, d};
    // no cycle limit of its own: a hang is left to the watchdog
    do begin
      @(posedge clk);
    end while (wt !== 1'h0);
    q = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : bus
  task automatic conv(input logic [15:0] v);
    @(posedge clk);
    val <= v;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    hi = 0;
    repeat (slow ? 130 : 60) begin
      @(posedge clk);
      if (alert === 1'h1) hi++;
    end
  endtask : conv
  task automatic ara(input logic [6:0] rival);
    @(posedge clk);
    ara_go <= 1'h1;
    @(posedge clk);
    ara_go <= 1'h0;
    seen = 1'h0;
    repeat (2) @(posedge clk);
    for (int k = 6; k >= 0; k--) begin
      other <= rival[k];
      @(posedge clk);
      stb <= 1'h1;
      @(posedge clk);
      stb <= 1'h0;
    end
    repeat (4) begin
      @(posedge clk);
      if (won === 1'h1) seen = 1'h1;
    end
    other <= 1'h1;
  endtask : ara
  task automatic t_reset();
    bus(0, 3'h2, 16'h0000);
    check(q, 32'h0000_8000);
    bus(0, 3'h3, 16'h0000);
    check(q, 32'h0000_7fff);
    bus(0, 3'h1, 16'h0000);
    check(q, 32'h0000_8583);
    check({oe, gain, ss, rate}, {1'h0, 3'h2, 1'h1, 3'h4});
    bus(1, 3'h6, 16'h1234);
    bus(0, 3'h6, 16'h0000);
    check(q, 32'h0000_0000);
  endtask : t_reset
  task automatic t_fields();
    for (int k = 0; k < 8; k++) begin
      g = k[2:0];
      bus(1, 3'h1, {4'h0, g, 1'h0, g, 5'h03});
      repeat (2) @(posedge clk);
      check({gain, ss, rate}, {g, 1'h0, g});
      bus(0, 3'h1, 16'h0000);
      check(q, {16'h0000, 1'h1, 3'h0, g, 1'h0, g, 5'h03});
    end
    bus(1, 3'h2, 16'hff00);
    bus(1, 3'h3, 16'h0100);
    bus(0, 3'h2, 16'h0000);
    check(q, 32'h0000_ff00);
  endtask : t_fields
  task automatic t_trad();
    bus(1, 3'h1, 16'h0480);
    bus(1, 3'h5, 16'h0001);
    conv(16'h0200);
    check({alert, irq}, 2'h1);
    conv(16'h0000);
    check(alert, 1'h0);
    conv(16'hfe00);
    check(alert, 1'h1);
    bus(1, 3'h5, 16'h0000);
    repeat (2) @(posedge clk);
    check(irq, 1'h0);
    bus(1, 3'h5, 16'h0001);
    repeat (2) @(posedge clk);
    check(irq, 1'h1);
    bus(1, 3'h4, 16'h0007);
    repeat (2) @(posedge clk);
    check(irq, 1'h0);
  endtask : t_trad
  task automatic t_queue(input logic [1:0] qc, input int need);
    bus(1, 3'h1, {14'h0126, qc});
    conv(16'h0000);
    for (int k = 1; k <= need; k++) begin
      conv(16'h0200);
      check(alert, k == need);
    end
    conv(16'hfe00);
    check(alert, 1'h1);
    conv(16'h0000);
    check(alert, 1'h0);
  endtask : t_queue
  task automatic t_latch();
    bus(1, 3'h1, 16'h049c);
    conv(16'h0200);
    conv(16'h0000);
    check(alert, 1'h1);
    bus(0, 3'h0, 16'h0000);
    check(q, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(alert, 1'h0);
    conv(16'h0200);
    ara(7'h7f);
    check({seen, alert}, 2'h2);
    conv(16'h0200);
    ara(7'h20);
    check({seen, alert}, 2'h1);
    check(sda_o, 1'h0);
    bus(0, 3'h0, 16'h0000);
  endtask : t_latch
  task automatic t_ready();
    bus(1, 3'h3, 16'h8000);
    bus(1, 3'h2, 16'h0000);
    bus(1, 3'h1, 16'h0488);
    conv(16'h1234);
    check(hi, 8);
    bus(1, 3'h1, 16'h0588);
    // single-shot and idle: a written start bit gives one start pulse
    bus(1, 3'h1, 16'h8588);
    @(posedge clk);
    check(start, 1'h1);
    @(posedge clk);
    check(start, 1'h0);
    slow <= 1'h1;
    repeat (3) @(posedge clk);
    check(alert, 1'h1);
    go <= 1'h1;
    repeat (40) @(posedge clk);
    check(alert, 1'h0);
    go <= 1'h0;
    repeat (100) @(posedge clk);
    check(alert, 1'h1);
    bus(1, 3'h1, 16'h0583);
    repeat (3) @(posedge clk);
    check(oe, 1'h0);
  endtask : t_ready
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_fields();
    t_trad();
    t_queue(2'h0, 1);
    t_queue(2'h1, 2);
    t_queue(2'h2, 4);
    t_latch();
    t_ready();
    give_verdict();
  end
  // generous bound over the whole sequence
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule : adc_config_threshold_alert_bench
bind acta_top acta_chk chk (.CORE_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_WAITREQUEST, .GAIN_RANGE_SELECT, .SINGLE_SHOT_MODE,
  .SAMPLE_RATE_SELECT, .CONV_START, .ALERT_OE, .ARA_BIT_STROBE, .ARA_SDA_IN, .ARA_SDA_OE,
  .ARA_WON);
`default_nettype wire
